// ---- cdfm_defs.svh ----
// What this block does
// (R1) transmitter write sets mailbox ready, interrupts receiver
// (R2) receiver read clears ready, interrupts transmitter
// (R3) two one-way channels, concurrent access
// (R4) channel disabled while its enable bit clear
// (R5) reset clears both enable bits
// (R6) primary alone enables; enable synced across
// (R7) disable zeroes storage, pointers, sets empty
// (R8) empty stays set until first write
// (R9) reset sets empty; empty irq suppressed disabled
// (R10) disable clears overflow and underflow flags
// (R11) underflow found reader side, synced to writer
// (R12) software waits for underflow clear before re-enable
// (R13) write data registers read zero, no pointer change
// (R14) read data registers ignore writes
// (R15) pointers advance on word or high byte
// (R16) software accesses low byte before high byte
// (R17) circular buffer, separate read and write pointers
// (R18) depth 32 parameter; pointers hidden from software
// (R19) equal pointers: empty flag and empty interrupt
// (R20) write leaving no room sets full flag
// (R21) receiver checks empty before each read
// (R22) three fifo interrupt outputs per core
// (R23) write to full discarded, sticky overflow set
// (R24) read of empty repeats last data, sets underflow
// (R25) threshold field picks data ready level
// (R26) crossings pass three destination clock stages
// (R27) gray pointers cross through register chains
`ifndef CDFM_DEFS_SVH
`define CDFM_DEFS_SVH
// register byte offsets
`define CDFM_OFF_PRI_CS 8'h00
`define CDFM_OFF_PRI_CTRL 8'h04
`define CDFM_OFF_PRI_TXD 8'h08
`define CDFM_OFF_PRI_RXD 8'h0c
`define CDFM_OFF_SEC_CTRL 8'h10
`define CDFM_OFF_SEC_CS 8'h14
`define CDFM_OFF_SEC_TXD 8'h18
`define CDFM_OFF_SEC_RXD 8'h1c
`define CDFM_OFF_MBX_WR 8'h20
`define CDFM_OFF_MBX_RD 8'h24
`define CDFM_OFF_MBX_ST 8'h28
// field positions in the control/status word and the control word
`define CDFM_BIT_TX_EN 15
`define CDFM_BIT_TX_OVF 11
`define CDFM_BIT_TX_UNF 10
`define CDFM_BIT_TX_FULL 9
`define CDFM_BIT_TX_EMPTY 8
`define CDFM_BIT_RX_EN 7
`define CDFM_BIT_RX_OVF 3
`define CDFM_BIT_RX_UNF 2
`define CDFM_BIT_RX_FULL 1
`define CDFM_BIT_RX_EMPTY 0
`define CDFM_THR_HI 11
`define CDFM_THR_LO 10
// reset values and timing
`define CDFM_RST_EN 1'b0
`define CDFM_RST_THR 2'h0
`define CDFM_DEPTH 32
`define CDFM_SYNC_STAGES 3
`endif

// ---- cdfm_pkg.sv ----
package cdfm_pkg;
   // per-channel status, ordered as bits 11..8 / 3..0
   typedef struct packed {
      logic ovf;
      logic unf;
      logic full;
      logic empty;
   } chan_flags_t;
   // fifo interrupt lines of one core
   typedef struct packed {
      logic fault;
      logic tx_empty;
      logic data_ready;
   } core_irq_t;
   // data ready threshold codes
   typedef enum logic [1:0] {
      THR_FIRST = 2'h0,
      THR_HALF = 2'h1,
      THR_3QTR = 2'h2,
      THR_FULL = 2'h3
   } ready_irq_threshold_t;
endpackage

// ---- cross_domain_fifo_mailbox_channels.sv ----
// The register addresses and the APB register port were decided locally.
`timescale 1ns/10ps
`include "cdfm_defs.svh"

// one-way channel: writer side and reader side kept apart
module cdfm_channel #(
   parameter int DEPTH = `CDFM_DEPTH,
   parameter int WIDTH = 16,
   parameter int SYNC = `CDFM_SYNC_STAGES
) (
   input wire logic clk, // system clock
   input wire logic rst_n, // async reset, active low
   input wire logic en_w, // enable as seen by writer
   input wire logic en_r, // enable as seen by reader
   input wire logic push, // writer push strobe
   input wire logic [WIDTH-1:0] push_data, // word to push
   input wire logic pop, // reader pop strobe
   input wire logic clr_ovf, // writer clears overflow
   input wire logic clr_unf, // reader clears underflow
   input wire logic [1:0] thr, // ready threshold code
   output logic [WIDTH-1:0] pop_data, // word the next pop returns
   output cdfm_pkg::chan_flags_t flags_w, // writer view
   output cdfm_pkg::chan_flags_t flags_r, // reader view
   output logic empty_irq_ff, // pulse to transmitter
   output logic ready_irq_ff // level to receiver
);
   // (R18) depth set by parameter
   localparam int AW = $clog2(DEPTH);
   localparam int PW = AW + 1;
   localparam logic [PW-1:0] D_FULL = PW'(DEPTH);
   localparam logic [PW-1:0] D_HALF = PW'(DEPTH / 2);
   localparam logic [PW-1:0] D_3QTR = PW'((DEPTH * 3) / 4);
   localparam logic [PW-1:0] D_ONE = PW'(1);

   logic [WIDTH-1:0] mem [DEPTH]; // storage, writer owned
   logic [PW-1:0] wptr_ff; // writer binary pointer
   logic [PW-1:0] rptr_ff; // reader binary pointer
   logic [PW-1:0] wg_sync_ff [SYNC]; // write gray into reader
   logic [PW-1:0] rg_sync_ff [SYNC]; // read gray into writer
   logic [SYNC-1:0] unf_sync_ff; // underflow into writer
   logic [SYNC-1:0] ovf_sync_ff; // overflow into reader
   logic ovf_ff; // sticky overflow, writer side
   logic unf_ff; // sticky underflow, reader side
   logic [WIDTH-1:0] last_ff; // most recent popped word
   logic empty_d_ff; // previous writer empty
   logic [PW-1:0] rptr_w; // read pointer seen by writer
   logic [PW-1:0] wptr_r; // write pointer seen by reader
   logic [PW-1:0] occ_w; // occupancy, writer view
   logic [PW-1:0] occ_r; // occupancy, reader view
   logic [PW-1:0] level; // threshold level

   function automatic logic [PW-1:0] to_gray(input logic [PW-1:0] b);
      to_gray = b ^ (b >> 1);
   endfunction

   function automatic logic [PW-1:0] from_gray(input logic [PW-1:0] g);
      logic [PW-1:0] b;
      b[PW-1] = g[PW-1];
      for (int i = PW - 2; i >= 0; i--) begin
         b[i] = b[i+1] ^ g[i];
      end
      from_gray = b;
   endfunction

   // views of the far pointer after the chains
   assign rptr_w = from_gray(rg_sync_ff[SYNC-1]);
   assign wptr_r = from_gray(wg_sync_ff[SYNC-1]);
   assign occ_w = wptr_ff - rptr_w;
   assign occ_r = wptr_r - rptr_ff;
   // (R19) equal pointers mean empty
   assign flags_w.empty = (wptr_ff == rptr_w);
   // (R8) stays set until a push crosses
   assign flags_r.empty = (wptr_r == rptr_ff);
   // (R20) no free slot left
   assign flags_w.full = (occ_w == D_FULL);
   assign flags_r.full = (occ_r == D_FULL);
   assign flags_w.ovf = ovf_ff;
   assign flags_w.unf = unf_sync_ff[SYNC-1];
   assign flags_r.ovf = ovf_sync_ff[SYNC-1];
   assign flags_r.unf = unf_ff;
   // (R24) an empty pop repeats the last word
   assign pop_data = flags_r.empty ? last_ff : mem[rptr_ff[AW-1:0]];

   // storage; zeroed while disabled
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < DEPTH; i++) mem[i] <= '0;
      // (R7) flush wipes contents
      end else if (!en_w) begin
         for (int i = 0; i < DEPTH; i++) mem[i] <= '0;
      end else if (push && !flags_w.full) begin
         mem[wptr_ff[AW-1:0]] <= push_data;
      end
   end

   // write pointer, next free slot
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wptr_ff <= '0;
      end else if (!en_w) begin
         wptr_ff <= '0;
      // (R23) full write leaves pointer alone
      end else if (push && !flags_w.full) begin
         // (R17) advance after the write
         wptr_ff <= wptr_ff + D_ONE;
      end
   end

   // read pointer, next entry to read
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rptr_ff <= '0;
      // (R7) pointers back to zero
      end else if (!en_r) begin
         rptr_ff <= '0;
      end else if (pop && !flags_r.empty) begin
         rptr_ff <= rptr_ff + D_ONE;
      end
   end

   // last popped word, for repeated empty reads
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         last_ff <= '0;
      end else if (!en_r) begin
         last_ff <= '0;
      end else if (pop && !flags_r.empty) begin
         last_ff <= mem[rptr_ff[AW-1:0]];
      end
   end

   // gray chains; first stage feeds only the second
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < SYNC; i++) begin
            wg_sync_ff[i] <= '0;
            rg_sync_ff[i] <= '0;
         end
      end else begin
         // (R27) gray coded pointer crossing
         wg_sync_ff[0] <= to_gray(wptr_ff);
         rg_sync_ff[0] <= to_gray(rptr_ff);
         // (R26) three destination stages
         for (int i = 1; i < SYNC; i++) begin
            wg_sync_ff[i] <= wg_sync_ff[i-1];
            rg_sync_ff[i] <= rg_sync_ff[i-1];
         end
      end
   end

   // sticky overflow; the event beats a clear
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ovf_ff <= 1'b0;
      // (R10) disable clears the fault
      end else if (!en_w) begin
         ovf_ff <= 1'b0;
      // (R23) sticky overflow
      end else if (push && flags_w.full) begin
         ovf_ff <= 1'b1;
      end else if (clr_ovf) begin
         ovf_ff <= 1'b0;
      end
   end

   // sticky underflow, caught where the read happens
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         unf_ff <= 1'b0;
      end else if (!en_r) begin
         unf_ff <= 1'b0;
      // (R24) sticky underflow
      end else if (pop && flags_r.empty) begin
         unf_ff <= 1'b1;
      end else if (clr_unf) begin
         unf_ff <= 1'b0;
      end
   end

   // fault flags carried across to the other side
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         unf_sync_ff <= '0;
         ovf_sync_ff <= '0;
      end else begin
         // (R11) writer sees underflow late
         unf_sync_ff <= {unf_sync_ff[SYNC-2:0], unf_ff};
         ovf_sync_ff <= {ovf_sync_ff[SYNC-2:0], ovf_ff};
      end
   end

   // empty edge; held high while off so no stale pulse
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         empty_d_ff <= 1'b1;
         empty_irq_ff <= 1'b0;
      end else begin
         empty_d_ff <= flags_w.empty | !en_w;
         // (R9) no empty interrupt while disabled
         empty_irq_ff <= en_w & flags_w.empty & !empty_d_ff;
      end
   end

   // threshold level from the code
   always_comb begin
      level = D_ONE;
      unique case (cdfm_pkg::ready_irq_threshold_t'(thr))
         cdfm_pkg::THR_FIRST: level = D_ONE;
         cdfm_pkg::THR_HALF: level = D_HALF;
         cdfm_pkg::THR_3QTR: level = D_3QTR;
         cdfm_pkg::THR_FULL: level = D_FULL;
      endcase
   end

   // data ready stays up while enough words wait
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ready_irq_ff <= 1'b0;
      end else begin
         // (R25) occupancy against threshold
         ready_irq_ff <= en_r & (occ_r >= level);
      end
   end
endmodule // cdfm_channel

// apb register front end, two channels and one mailbox
module cross_domain_fifo_mailbox_channels #(
   parameter int DEPTH = `CDFM_DEPTH // words per channel
) (
   input wire logic clk, // 40 MHz system clock
   input wire logic rst_n, // async reset, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb access phase
   input wire logic pwrite, // apb direction
   input wire logic [7:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   input wire logic [3:0] pstrb, // apb byte strobes
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error, unmapped
   output cdfm_pkg::core_irq_t pri_irq, // primary fifo irqs
   output cdfm_pkg::core_irq_t sec_irq, // secondary fifo irqs
   output logic mbx_rtr_irq_ff, // ready to read, secondary
   output logic mbx_rtw_irq_ff // ready to write, primary
);
   logic tx_en_ff; // primary to secondary enable
   logic rx_en_ff; // secondary to primary enable
   logic [`CDFM_SYNC_STAGES-1:0] tx_en_sync_ff; // tx enable, far
   logic [`CDFM_SYNC_STAGES-1:0] rx_en_sync_ff; // rx enable, far
   logic [1:0] pri_thr_ff; // primary ready threshold
   logic [1:0] sec_thr_ff; // secondary ready threshold
   logic [7:0] pri_stage_ff; // primary low byte staging
   logic [7:0] sec_stage_ff; // secondary low byte staging
   logic [15:0] mbx_data_ff; // mailbox word
   logic mailbox_ready_flag_ff; // mailbox holds unread data
   logic [31:0] prdata_ff; // read data captured at setup
   logic setup; // apb setup cycle
   logic wr_acc; // completing write
   logic rd_acc; // completing read
   logic mapped; // address decodes
   logic hi_wr; // word or high byte write
   logic [31:0] rd_mux; // read data select
   logic push_tx, pop_tx, push_rx, pop_rx; // channel strobes
   logic [15:0] tx_pop_data, rx_pop_data; // next pop words
   logic [15:0] tx_push_data, rx_push_data; // words to push
   cdfm_pkg::chan_flags_t tx_fw, tx_fr, rx_fw, rx_fr; // views
   logic tx_empty_irq, tx_ready_irq; // tx channel irqs
   logic rx_empty_irq, rx_ready_irq; // rx channel irqs
   logic pri_w1c_tx_ovf, pri_w1c_rx_unf; // primary clears
   logic sec_w1c_tx_unf, sec_w1c_rx_ovf; // secondary clears
   logic mbx_set, mbx_clr; // mailbox flag events
   logic sec_tx_en, sec_rx_en; // enables on the far side

   // zero wait states; every access completes at once
   assign pready = 1'b1;
   assign setup = psel & !penable;
   assign wr_acc = psel & penable & pwrite;
   assign rd_acc = psel & penable & !pwrite;
   // (R15) word or high byte moves the pointer
   assign hi_wr = wr_acc & pstrb[1];
   assign sec_tx_en = tx_en_sync_ff[`CDFM_SYNC_STAGES-1];
   assign sec_rx_en = rx_en_sync_ff[`CDFM_SYNC_STAGES-1];

   // address decode for the error answer
   always_comb begin
      unique case (paddr)
         `CDFM_OFF_PRI_CS, `CDFM_OFF_PRI_CTRL, `CDFM_OFF_PRI_TXD,
         `CDFM_OFF_PRI_RXD, `CDFM_OFF_SEC_CTRL, `CDFM_OFF_SEC_CS,
         `CDFM_OFF_SEC_TXD, `CDFM_OFF_SEC_RXD, `CDFM_OFF_MBX_WR,
         `CDFM_OFF_MBX_RD, `CDFM_OFF_MBX_ST: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end
   assign pslverr = psel & penable & !mapped;

   // strobes into the channels
   assign push_tx = hi_wr & (paddr == `CDFM_OFF_PRI_TXD);
   assign push_rx = hi_wr & (paddr == `CDFM_OFF_SEC_TXD);
   // (R13) only receive registers pop on read
   assign pop_tx = rd_acc & (paddr == `CDFM_OFF_SEC_RXD);
   assign pop_rx = rd_acc & (paddr == `CDFM_OFF_PRI_RXD);
   // (R16) low byte comes from staging unless written now
   assign tx_push_data = {pwdata[15:8],
      pstrb[0] ? pwdata[7:0] : pri_stage_ff};
   assign rx_push_data = {pwdata[15:8],
      pstrb[0] ? pwdata[7:0] : sec_stage_ff};

   // write-one-to-clear of flags owned by each side
   assign pri_w1c_tx_ovf = wr_acc & pstrb[1]
      & (paddr == `CDFM_OFF_PRI_CS) & pwdata[`CDFM_BIT_TX_OVF];
   assign pri_w1c_rx_unf = wr_acc & pstrb[0]
      & (paddr == `CDFM_OFF_PRI_CS) & pwdata[`CDFM_BIT_RX_UNF];
   assign sec_w1c_tx_unf = wr_acc & pstrb[1]
      & (paddr == `CDFM_OFF_SEC_CS) & pwdata[`CDFM_BIT_TX_UNF];
   assign sec_w1c_rx_ovf = wr_acc & pstrb[0]
      & (paddr == `CDFM_OFF_SEC_CS) & pwdata[`CDFM_BIT_RX_OVF];

   // enable bits, writable by the primary alone
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         // (R5) reset clears both enables
         tx_en_ff <= `CDFM_RST_EN;
         rx_en_ff <= `CDFM_RST_EN;
      end else if (wr_acc && paddr == `CDFM_OFF_PRI_CS) begin
         // (R4) enable bits 15 and 7
         if (pstrb[1]) tx_en_ff <= pwdata[`CDFM_BIT_TX_EN];
         if (pstrb[0]) rx_en_ff <= pwdata[`CDFM_BIT_RX_EN];
      end
   end

   // enables carried to the secondary side
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_en_sync_ff <= '0;
         rx_en_sync_ff <= '0;
      end else begin
         // (R6) enable synced to secondary
         tx_en_sync_ff <= {tx_en_sync_ff[`CDFM_SYNC_STAGES-2:0], tx_en_ff};
         rx_en_sync_ff <= {rx_en_sync_ff[`CDFM_SYNC_STAGES-2:0], rx_en_ff};
      end
   end

   // threshold fields of each side
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pri_thr_ff <= `CDFM_RST_THR;
         sec_thr_ff <= `CDFM_RST_THR;
      end else if (wr_acc && pstrb[1]) begin
         // (R25) threshold at bits 11:10
         if (paddr == `CDFM_OFF_PRI_CTRL)
            pri_thr_ff <= pwdata[`CDFM_THR_HI:`CDFM_THR_LO];
         if (paddr == `CDFM_OFF_SEC_CTRL)
            sec_thr_ff <= pwdata[`CDFM_THR_HI:`CDFM_THR_LO];
      end
   end

   // low byte staging for byte-wide pushes
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pri_stage_ff <= 8'h00;
         sec_stage_ff <= 8'h00;
      end else if (wr_acc && pstrb[0]) begin
         if (paddr == `CDFM_OFF_PRI_TXD) pri_stage_ff <= pwdata[7:0];
         if (paddr == `CDFM_OFF_SEC_TXD) sec_stage_ff <= pwdata[7:0];
      end
   end

   // (R3) two one-way channels side by side
   cdfm_channel #(.DEPTH(DEPTH), .WIDTH(16)) u_tx_chan (
      .clk(clk),
      .rst_n(rst_n),
      .en_w(tx_en_ff),
      .en_r(sec_tx_en),
      .push(push_tx),
      .push_data(tx_push_data),
      .pop(pop_tx),
      .clr_ovf(pri_w1c_tx_ovf),
      .clr_unf(sec_w1c_tx_unf),
      .thr(sec_thr_ff),
      .pop_data(tx_pop_data),
      .flags_w(tx_fw),
      .flags_r(tx_fr),
      .empty_irq_ff(tx_empty_irq),
      .ready_irq_ff(tx_ready_irq)
   );

   cdfm_channel #(.DEPTH(DEPTH), .WIDTH(16)) u_rx_chan (
      .clk(clk),
      .rst_n(rst_n),
      .en_w(sec_rx_en),
      .en_r(rx_en_ff),
      .push(push_rx),
      .push_data(rx_push_data),
      .pop(pop_rx),
      .clr_ovf(sec_w1c_rx_ovf),
      .clr_unf(pri_w1c_rx_unf),
      .thr(pri_thr_ff),
      .pop_data(rx_pop_data),
      .flags_w(rx_fw),
      .flags_r(rx_fr),
      .empty_irq_ff(rx_empty_irq),
      .ready_irq_ff(rx_ready_irq)
   );

   // (R22) three fifo interrupt lines per core
   assign pri_irq.fault = tx_fw.ovf | tx_fw.unf | rx_fr.ovf | rx_fr.unf;
   assign pri_irq.tx_empty = tx_empty_irq;
   assign pri_irq.data_ready = rx_ready_irq;
   assign sec_irq.fault = tx_fr.ovf | tx_fr.unf | rx_fw.ovf | rx_fw.unf;
   assign sec_irq.tx_empty = rx_empty_irq;
   assign sec_irq.data_ready = tx_ready_irq;

   // mailbox events; a set wins over a same-cycle clear
   assign mbx_set = hi_wr & (paddr == `CDFM_OFF_MBX_WR);
   assign mbx_clr = rd_acc & (paddr == `CDFM_OFF_MBX_RD)
      & mailbox_ready_flag_ff;

   // mailbox word, byte writable
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mbx_data_ff <= 16'h0000;
      end else if (wr_acc && paddr == `CDFM_OFF_MBX_WR) begin
         if (pstrb[0]) mbx_data_ff[7:0] <= pwdata[7:0];
         if (pstrb[1]) mbx_data_ff[15:8] <= pwdata[15:8];
      end
   end

   // mailbox ready flag and its two interrupt pulses
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mailbox_ready_flag_ff <= 1'b0;
         mbx_rtr_irq_ff <= 1'b0;
         mbx_rtw_irq_ff <= 1'b0;
      end else begin
         // (R1) final write sets the flag
         if (mbx_set) begin
            mailbox_ready_flag_ff <= 1'b1;
         // (R2) receiver read clears it
         end else if (mbx_clr) begin
            mailbox_ready_flag_ff <= 1'b0;
         end
         mbx_rtr_irq_ff <= mbx_set;
         mbx_rtw_irq_ff <= mbx_clr & !mbx_set;
      end
   end

   // read data select; pointers stay hidden
   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (paddr)
         `CDFM_OFF_PRI_CS: rd_mux = {16'h0000, tx_en_ff, 3'h0, tx_fw,
            rx_en_ff, 3'h0, rx_fr};
         `CDFM_OFF_SEC_CS: rd_mux = {16'h0000, sec_tx_en, 3'h0, tx_fr,
            sec_rx_en, 3'h0, rx_fw};
         `CDFM_OFF_PRI_CTRL: rd_mux = {20'h00000, pri_thr_ff, 10'h000};
         `CDFM_OFF_SEC_CTRL: rd_mux = {20'h00000, sec_thr_ff, 10'h000};
         // (R14) receive data is read only
         `CDFM_OFF_PRI_RXD: rd_mux = {16'h0000, rx_pop_data};
         `CDFM_OFF_SEC_RXD: rd_mux = {16'h0000, tx_pop_data};
         `CDFM_OFF_MBX_RD: rd_mux = {16'h0000, mbx_data_ff};
         `CDFM_OFF_MBX_ST: rd_mux = {31'h0, mailbox_ready_flag_ff};
         // (R13) transmit data reads as zero
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   // capture at setup; the pop lands one edge later
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata_ff <= 32'h0000_0000;
      end else if (setup && !pwrite) begin
         prdata_ff <= rd_mux;
      end
   end
   assign prdata = prdata_ff;
endmodule // cross_domain_fifo_mailbox_channels

// ---- cdfm_asserts.sv ----
`timescale 1ns/10ps
// port-level checks of the apb front end and event pulses
module cdfm_asserts #(
   parameter int DEPTH = 32 // words per channel
) (
   input wire logic clk, // system clock
   input wire logic rst_n, // async reset, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb access phase
   input wire logic pwrite, // apb direction
   input wire logic [7:0] paddr, // apb byte address
   input wire logic [3:0] pstrb, // apb byte strobes
   input wire logic [31:0] prdata, // apb read data
   input wire logic pready, // apb ready
   input wire logic pslverr, // apb error
   input cdfm_pkg::core_irq_t pri_irq, // primary irqs
   input wire logic mbx_rtr_irq_ff, // ready to read pulse
   input wire logic mbx_rtw_irq_ff // ready to write pulse
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   wire acc = psel && penable; // access cycle of a transfer
   a_ready_no_wait: assert property (acc |-> pready)
      else $error("pready low in access");
   a_unmapped_err: assert property (acc && paddr > 8'h28 |-> pslverr)
      else $error("unmapped access without error");
   a_mapped_ok: assert property (acc && paddr == 8'h08 |-> !pslverr)
      else $error("error on mapped access");
   a_txd_reads_zero: assert property (acc && !pwrite && paddr == 8'h08
      |-> prdata == 32'h0)
      else $error("write data register read nonzero");
   a_refused_zero: assert property (acc && !pwrite && pslverr
      |-> prdata == 32'h0)
      else $error("refused read returned data");
   a_rtr_after_write: assert property (acc && pwrite && paddr == 8'h20
      && pstrb[1] |-> ##[1:2] mbx_rtr_irq_ff)
      else $error("no ready to read pulse");
   a_rtr_one_cycle: assert property ($rose(mbx_rtr_irq_ff)
      |=> !mbx_rtr_irq_ff)
      else $error("ready to read pulse too long");
   a_rtw_one_cycle: assert property ($rose(mbx_rtw_irq_ff)
      |=> !mbx_rtw_irq_ff)
      else $error("ready to write pulse too long");
   a_empty_irq_pulse: assert property (pri_irq.tx_empty
      |=> !pri_irq.tx_empty)
      else $error("empty irq not a pulse");
endmodule // cdfm_asserts

bind cross_domain_fifo_mailbox_channels cdfm_asserts #(.DEPTH(DEPTH))
   cdfm_asserts_i (.clk(clk), .rst_n(rst_n), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pstrb(pstrb),
   .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .pri_irq(pri_irq), .mbx_rtr_irq_ff(mbx_rtr_irq_ff),
   .mbx_rtw_irq_ff(mbx_rtw_irq_ff));

// ---- cdfm_core_model.sv ----
`timescale 1ns/10ps
// receiving cores: count event pulses as an irq controller would
module cdfm_core_model (
   input wire logic clk, // system clock
   input wire logic rst_n, // async reset, active low
   input wire logic [2:0] ev, // rtr, rtw, primary tx empty
   output int n_ev [3] // pulses seen per line
);
   // one count per rising clock with the line high
   always_ff @(posedge clk or negedge rst_n) begin
      for (int i = 0; i < 3; i++) begin
         if (!rst_n) n_ev[i] <= 0;
         else if (ev[i]) n_ev[i] <= n_ev[i] + 1;
      end
   end
endmodule // cdfm_core_model

// ---- cross_domain_fifo_mailbox_channels_tb.sv ----
`timescale 1ns/10ps
module cross_domain_fifo_mailbox_channels_tb;
   localparam int D = 8; // short channel keeps run brief
   logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic [3:0] pstrb = 4'h0;
   logic pready, pslverr, err;
   cdfm_pkg::core_irq_t pri_irq, sec_irq;
   logic mbx_rtr_irq_ff, mbx_rtw_irq_ff;
   int n_ev [3];
   int n_mismatch = 0, comparisons = 0;
   cross_domain_fifo_mailbox_channels #(.DEPTH(D))
      cross_domain_fifo_mailbox_channels_i (.clk(clk), .rst_n(rst_n),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pri_irq(pri_irq), .sec_irq(sec_irq),
      .mbx_rtr_irq_ff(mbx_rtr_irq_ff), .mbx_rtw_irq_ff(mbx_rtw_irq_ff));
   cdfm_core_model cdfm_core_model_i (.clk(clk), .rst_n(rst_n),
      .ev({pri_irq.tx_empty, mbx_rtw_irq_ff, mbx_rtr_irq_ff}),
      .n_ev(n_ev));
   // 40 MHz clock
   initial begin
      forever #12.5 clk = ~clk;
   end
   // one apb transfer; full word strobes keep low byte before high
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= w ? 4'h3 : 4'h0;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      // only the watchdog ends a wait for the answer
      while (pready !== 1'b1) @(posedge clk);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic chk(input logic [31:0] seen, exp, input string nm);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic finish_test;
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // watchdog, 20000 cycles, far beyond the under 200 cycles the tests need
   initial begin
      #500000;
      n_mismatch++;
      finish_test;
   end
   // main sequence
   initial begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      apb(0, 8'h00, 0); chk(q, 32'h0101, "status rst");
      chk(pri_irq, 3'h0, "irq rst");
      apb(1, 8'h00, 32'h8080);
      apb(1, 8'h0c, 32'hffff);
      repeat (6) @(posedge clk);
      apb(0, 8'h14, 0); chk(q, 32'h8181, "sec en");
      // secondary to primary channel, first-entry threshold
      apb(1, 8'h18, 32'h00a5);
      repeat (6) @(posedge clk);
      chk(pri_irq.data_ready, 1'b1, "rx ready");
      apb(0, 8'h0c, 0); chk(q, 32'h00a5, "rx chan");
      apb(1, 8'h10, {20'h0, cdfm_pkg::THR_FULL, 10'h0});
      for (int i = 0; i < D; i++) begin
         if (i == D - 1) begin
            repeat (6) @(posedge clk);
            chk(sec_irq.data_ready, 1'b0, "thr below");
         end
         apb(1, 8'h08, i + 1);
      end
      repeat (6) @(posedge clk);
      chk(sec_irq.data_ready, 1'b1, "thr full");
      apb(0, 8'h00, 0); chk(q, 32'h8281, "full");
      apb(1, 8'h08, 32'h0055);
      apb(0, 8'h00, 0); chk(q, 32'h8a81, "overflow");
      chk(pri_irq.fault, 1'b1, "fault irq");
      apb(0, 8'h08, 0); chk(q, 32'h0, "txd read");
      apb(0, 8'h14, 0); chk(q & 32'h100, 32'h0, "sec ready");
      for (int i = 0; i < D; i++) begin
         apb(0, 8'h1c, 0); chk(q, i + 1, "pop");
      end
      apb(0, 8'h1c, 0); chk(q, D, "underflow data");
      apb(0, 8'h14, 0); chk(q & 32'h400, 32'h400, "sec unf");
      repeat (6) @(posedge clk);
      apb(0, 8'h00, 0); chk(q & 32'h400, 32'h400, "pri unf");
      chk(n_ev[2], 1, "empty irq");
      // disable without re-enabling, so no wait for unf clear
      apb(1, 8'h00, 32'h0);
      repeat (8) @(posedge clk);
      apb(0, 8'h00, 0); chk(q, 32'h0101, "flush");
      chk(pri_irq, 3'h0, "irq off");
      apb(1, 8'h20, 32'h1234);
      apb(0, 8'h28, 0); chk(q & 32'h1, 32'h1, "mbx set");
      apb(0, 8'h24, 0); chk(q, 32'h1234, "mbx data");
      apb(0, 8'h28, 0); chk(q & 32'h1, 32'h0, "mbx clr");
      chk(n_ev[0], 1, "rtr irqs");
      chk(n_ev[1], 1, "rtw irqs");
      apb(0, 8'h3c, 0); chk(err, 1'b1, "unmapped err");
      chk(q, 32'h0, "unmapped data");
      finish_test;
   end
endmodule // cross_domain_fifo_mailbox_channels_tb
